// ### hw/ssp_top.sv
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_top #(
	parameter int FIFO_DEPTH = `SSP_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial clock pin
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe_n,
	// Frame select pin
	input wire logic fss_i,
	output logic fss_o,
	output logic fss_oe_n,
	// Data pins
	output logic txd_o,
	output logic txd_oe_n,
	input wire logic rxd_i
);
	import ssp_pkg::*;
	ssp_ctrl0_t ctrl0_q;
	ssp_ctrl1_t ctrl1_q;
	ssp_state_t state_q;
	logic [7:0] presc_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_word;
	logic pready_q, pslverr_q, ovr_q, push_q, half_q, mapped, acc, done, stall, hit_data;
	logic [2:0] sync1_q, sync2_q;
	logic [1:0] prev_q;
	logic [4:0] bit_q, samp_cnt_q, n_bits, total, drv_idx, load_sh;
	logic [3:0] dss_eff;
	logic [15:0] tx_sh, rx_sh, tx_word, tx_load, tx_out_data, rx_out_data;
	logic txd_q, sclk_q, fss_q, sclk_oe_n_q, fss_oe_n_q, txd_oe_n_q;
	logic tx_in_ready, tx_out_valid, tx_out_ready, rx_in_ready, rx_out_valid, rx_out_ready;
	logic en, master, running, pol, pha, tick, lead, trail, samp, drive, last;
	logic sclk_s, fss_s, rxd_s, sclk_edge, fss_rise, fss_fall, s_start, start, abort;
	logic rx_bit, busy, tx_msb;

	// APB handshake: one wait state; a data write stalls while the transmit FIFO is full
	assign acc = psel & penable;
	assign hit_data = paddr == `SSP_OFF_DATA;
	assign stall = acc & pwrite & hit_data & ~tx_in_ready;
	assign done = acc & pready_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else if (pready_q) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (acc && !stall) begin
			pready_q <= 1'b1;
			pslverr_q <= ~mapped;
			prdata_q <= pwrite ? 32'h00000000 : rd_word;
		end
	end

	// Read mux; unmapped addresses read zero with an error
	always_comb begin
		rd_word = 32'h00000000;
		mapped = 1'b1;
		case (paddr)
			`SSP_OFF_CTRL0: rd_word = {16'h0000, ctrl0_q};
			`SSP_OFF_CTRL1: rd_word = {28'h0000000, ctrl1_q};
			`SSP_OFF_DATA: rd_word = {16'h0000, rx_out_valid ? rx_out_data : 16'h0000};
			`SSP_OFF_STAT: rd_word = {26'h0000000, ovr_q, busy, ~rx_in_ready, rx_out_valid,
				tx_in_ready, ~tx_out_valid};
			`SSP_OFF_PRESC: rd_word = {24'h000000, presc_q};
			default: mapped = 1'b0;
		endcase
	end

	// Control registers; writable whether the port is enabled or not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_q <= ssp_ctrl0_t'(`SSP_RST_CTRL0);
			ctrl1_q <= ssp_ctrl1_t'(`SSP_RST_CTRL1);
			presc_q <= `SSP_RST_PRESC;
		end else if (done && pwrite) begin
			if (paddr == `SSP_OFF_CTRL0) begin
				ctrl0_q <= ssp_ctrl0_t'(pwdata[15:0]); // [RQ2] [RQ3]
			end
			if (paddr == `SSP_OFF_CTRL1) begin
				ctrl1_q <= ssp_ctrl1_t'(pwdata[3:0]); // [RQ6] [RQ9]
			end
			if (paddr == `SSP_OFF_PRESC) begin
				presc_q <= pwdata[7:0]; // [RQ8]
			end
		end
	end

	// Overrun: a slave frame lost to a full receive FIFO; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_q <= 1'b0;
		end else if (push_q && !rx_in_ready) begin
			ovr_q <= 1'b1;
		end else if (done && pwrite && paddr == `SSP_OFF_STAT && pwdata[`SSP_STAT_OVR]) begin
			ovr_q <= 1'b0;
		end
	end

	// Transmit and receive queues, independent of each other
	ssp_fifo #(.W(`SSP_DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo ( // [RQ5]
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(done & pwrite & hit_data),
		.in_ready(tx_in_ready),
		.in_data(pwdata[15:0]),
		.out_valid(tx_out_valid),
		.out_ready(tx_out_ready),
		.out_data(tx_out_data)
	);
	assign rx_out_ready = done & ~pwrite & hit_data;
	ssp_fifo #(.W(`SSP_DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo ( // [RQ5]
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(push_q),
		.in_ready(rx_in_ready),
		.in_data(rx_sh),
		.out_valid(rx_out_valid),
		.out_ready(rx_out_ready),
		.out_data(rx_out_data)
	);

	// Pin synchronisers; only the second stage is looked at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 3'h2; // Idle pin levels, so release makes no false select edge
			sync2_q <= 3'h2;
			prev_q <= 2'h1;
		end else begin
			sync1_q <= {sclk_i, fss_i, rxd_i};
			sync2_q <= sync1_q;
			prev_q <= sync2_q[2:1];
		end
	end
	assign sclk_s = sync2_q[2];
	assign fss_s = sync2_q[1];
	assign rxd_s = sync2_q[0];

	// Frame shape per format; sizes below four are raised to four
	assign dss_eff = (ctrl0_q.dss < `SSP_MIN_DSS) ? `SSP_MIN_DSS : ctrl0_q.dss;
	assign n_bits = {1'b0, dss_eff} + 5'h01; // [RQ3]
	assign pol = (ctrl0_q.fmt == SSP_FMT_SPI) & ctrl0_q.cpol;
	assign pha = (ctrl0_q.fmt == SSP_FMT_PULSE) | ((ctrl0_q.fmt == SSP_FMT_SPI) & ctrl0_q.cpha);
	always_comb begin
		case (ctrl0_q.fmt)
			SSP_FMT_PULSE: total = n_bits + 5'h01; // [RQ2]
			SSP_FMT_CMD: total = n_bits + `SSP_CMD_BITS; // [RQ2]
			default: total = n_bits;
		endcase
	end

	// Bit slots that carry transmit data
	function automatic logic in_tx(input logic [4:0] b);
		case (ctrl0_q.fmt)
			SSP_FMT_PULSE: in_tx = (b != 5'h00) && (b <= n_bits);
			SSP_FMT_CMD: in_tx = b < `SSP_CMD_BITS;
			default: in_tx = b < n_bits;
		endcase
	endfunction

	// Bit slots that carry receive data; the command format listens only after its command
	function automatic logic in_rx(input logic [4:0] b);
		case (ctrl0_q.fmt)
			SSP_FMT_PULSE: in_rx = (b != 5'h00) && (b <= n_bits);
			SSP_FMT_CMD: in_rx = b >= `SSP_CMD_BITS;
			default: in_rx = b < n_bits;
		endcase
	endfunction

	// Serial clock generation for master operation
	assign en = ctrl1_q.en;
	assign master = ~ctrl1_q.slave;
	assign running = state_q == SSP_RUN;
	ssp_clkdiv u_clkdiv ( // [RQ8]
		.pclk(pclk),
		.presetn(presetn),
		.run(running & master),
		.presc(presc_q),
		.scr(ctrl0_q.scr),
		.tick(tick)
	);

	// Clock edges: own divider as master, sampled pin edges as slave
	assign sclk_edge = sclk_s ^ prev_q[1];
	assign lead = running & (master ? tick & ~half_q : sclk_edge & (sclk_s != pol)); // [RQ10]
	assign trail = running & (master ? tick & half_q : sclk_edge & (sclk_s == pol)); // [RQ10]
	assign samp = pha ? trail : lead;
	assign drive = pha ? lead : trail;
	assign drv_idx = pha ? bit_q : bit_q + 5'h01;
	assign last = trail & (bit_q == total - 5'h01);
	assign fss_fall = ~fss_s & prev_q[0];
	assign fss_rise = fss_s & ~prev_q[0];
	assign s_start = (ctrl0_q.fmt == SSP_FMT_PULSE) ? fss_rise : fss_fall;
	// Master waits for room in the receive queue so no word is dropped
	assign start = en & ~running & ~push_q & (master ? tx_out_valid & rx_in_ready : s_start);
	assign abort = running & ~master & (ctrl0_q.fmt != SSP_FMT_PULSE) & fss_rise;
	assign rx_bit = ctrl1_q.loop ? txd_q : rxd_s; // [RQ9]
	assign busy = running | tx_out_valid;

	// Frame sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SSP_IDLE;
			bit_q <= 5'h00;
			half_q <= 1'b0;
			push_q <= 1'b0;
		end else begin
			push_q <= last & en & ~abort;
			if (!en || abort) begin
				state_q <= SSP_IDLE;
			end else if (start) begin
				state_q <= SSP_RUN;
				bit_q <= 5'h00;
				half_q <= 1'b0;
			end else if (lead) begin
				half_q <= 1'b1;
			end else if (trail) begin
				half_q <= 1'b0;
				if (last) begin
					state_q <= SSP_IDLE; // [RQ3]
				end else begin
					bit_q <= bit_q + 5'h01;
				end
			end
		end
	end

	// Shift registers; an empty transmit queue sends zeros in slave frames
	assign tx_out_ready = start & tx_out_valid;
	assign tx_word = tx_out_valid ? tx_out_data : 16'h0000;
	assign load_sh = (ctrl0_q.fmt == SSP_FMT_CMD) ? `SSP_CMD_BITS : `SSP_WORD_BITS - n_bits;
	assign tx_load = tx_word << load_sh;
	assign tx_msb = tx_sh[15];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_sh <= 16'h0000;
			rx_sh <= 16'h0000;
			txd_q <= 1'b0;
		end else if (start) begin
			rx_sh <= 16'h0000;
			if (!pha && in_tx(5'h00)) begin
				txd_q <= tx_load[15];
				tx_sh <= tx_load << 1;
			end else begin
				tx_sh <= tx_load;
			end
		end else begin
			if (samp && in_rx(bit_q)) begin
				rx_sh <= {rx_sh[14:0], rx_bit}; // [RQ4]
			end
			if (drive && in_tx(drv_idx)) begin
				txd_q <= tx_sh[15]; // [RQ4]
				tx_sh <= tx_sh << 1;
			end
		end
	end

	// Count of received bits per frame, read only by a check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_cnt_q <= 5'h00;
		end else if (start) begin
			samp_cnt_q <= 5'h00;
		end else if (samp && in_rx(bit_q)) begin
			samp_cnt_q <= samp_cnt_q + 5'h01;
		end
	end

	// Pin drivers; enables are low while driving
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q <= 1'b0;
			fss_q <= 1'b1;
			sclk_oe_n_q <= 1'b1;
			fss_oe_n_q <= 1'b1;
			txd_oe_n_q <= 1'b1;
		end else begin
			sclk_oe_n_q <= ~(en & master); // [RQ10] [RQ1]
			fss_oe_n_q <= ~(en & master); // [RQ10] [RQ1]
			txd_oe_n_q <= ~(en & (master | (running & ~ctrl1_q.sod))); // [RQ7]
			if (!running) begin
				sclk_q <= pol;
			end else if (lead && master) begin
				sclk_q <= ~pol;
			end else if (trail && master) begin
				sclk_q <= pol;
			end
			// Frame-pulse format marks the frame with one high bit slot
			if (ctrl0_q.fmt == SSP_FMT_PULSE) begin
				fss_q <= running & (bit_q == 5'h00); // [RQ2]
			end else begin
				fss_q <= ~running; // [RQ2]
			end
		end
	end

	// Outputs straight from flip-flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign sclk_o = sclk_q;
	assign sclk_oe_n = sclk_oe_n_q;
	assign fss_o = fss_q;
	assign fss_oe_n = fss_oe_n_q;
	assign txd_o = txd_q;
	assign txd_oe_n = txd_oe_n_q;

	sequence s_wait;
		psel && penable && !pready_q && !stall;
	endsequence
	sequence s_pulse_begin;
		start && master && (ctrl0_q.fmt == SSP_FMT_PULSE);
	endsequence
	chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		s_wait |=> pready_q ##1 !pready_q)
		else $error("apb answer not one cycle");
	chk_master_pins: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
		en && master |=> !sclk_oe_n_q && !fss_oe_n_q)
		else $error("master not driving clock and select");
	chk_slave_pins: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
		!master |=> sclk_oe_n_q && fss_oe_n_q)
		else $error("slave drives clock or select");
	chk_slave_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
		ctrl1_q.slave && ctrl1_q.sod |=> txd_oe_n_q)
		else $error("disabled slave output driven");
	chk_frame_len: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
		push_q |-> samp_cnt_q == n_bits)
		else $error("received bit count differs from frame size");
	chk_tx_shift: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
		drive && in_tx(drv_idx) && !start |=> txd_q == $past(tx_msb))
		else $error("wrong bit shifted out");
	chk_loop_back: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
		ctrl1_q.loop && samp && in_rx(bit_q) |=> rx_sh[0] == $past(txd_q))
		else $error("loopback bit not received");
	chk_pulse_mark: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
		s_pulse_begin ##1 running |=> fss_q)
		else $error("frame pulse missing");
	chk_sclk_lead: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
		lead && master && en |=> sclk_q != pol)
		else $error("clock did not leave idle level");
	chk_link_data: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
		en && master ##1 en && master |-> !txd_oe_n_q)
		else $error("master data wire undriven");
endmodule // ssp_top

// ### hw/ssp_cfg.svh
// How it works
// [RQ1] Link has four wires: serial clock, frame select, transmit data, receive data.
// [RQ2] Three frame formats: polarity/phase, command-then-response, frame-pulse.
// [RQ3] Frame length programmable from 4 to 16 bits for every frame; command frames add an 8-bit command, pulse frames one extra slot.
// [RQ4] Incoming bits shift into words; outgoing words shift out bit by bit.
// [RQ5] Separate transmit and receive FIFOs, eight entries of 16 bits each.
// [RQ6] Port runs either as link master or as slave.
// [RQ7] Slave can keep its data output undriven to share the line.
// [RQ8] Serial clock comes from a prescaler then a bit-rate divider.
// [RQ9] Loopback mode routes transmitted data straight back into the receiver.
// [RQ10] Master drives clock and frame select; as slave both are sampled.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// Register byte offsets
`define SSP_OFF_CTRL0 8'h00
`define SSP_OFF_CTRL1 8'h04
`define SSP_OFF_DATA 8'h08
`define SSP_OFF_STAT 8'h0C
`define SSP_OFF_PRESC 8'h10

// Reset values
`define SSP_RST_CTRL0 16'h0007
`define SSP_RST_CTRL1 4'h0
`define SSP_RST_PRESC 8'h02

// Status bit used for write-one-to-clear
`define SSP_STAT_OVR 5

// Frame shaping
`define SSP_MIN_DSS 4'h3
`define SSP_CMD_BITS 5'h08
`define SSP_WORD_BITS 5'h10

// Storage shape
`define SSP_DATA_W 16
`define SSP_FIFO_DEPTH 8

`endif

// ### hw/ssp_pkg.sv
package ssp_pkg;

	// Frame formats
	typedef enum logic [1:0] {
		SSP_FMT_SPI,
		SSP_FMT_PULSE,
		SSP_FMT_CMD
	} ssp_fmt_t;

	// Engine states
	typedef enum logic {
		SSP_IDLE,
		SSP_RUN
	} ssp_state_t;

	// Frame shape and rate control
	typedef struct packed {
		logic [7:0] scr;
		logic cpha;
		logic cpol;
		ssp_fmt_t fmt;
		logic [3:0] dss;
	} ssp_ctrl0_t;

	// Operating control
	typedef struct packed {
		logic sod;
		logic slave;
		logic en;
		logic loop;
	} ssp_ctrl1_t;

endpackage

// ### hw/ssp_fifo.sv
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_fifo #(
	parameter int W = `SSP_DATA_W,
	parameter int DEPTH = `SSP_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import ssp_pkg::*;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// Honest flags straight from the occupancy count
	assign in_ready = cnt_q != FULL;
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage, data only, needs no reset
	always_ff @(posedge pclk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers wrap at any depth, not only powers of two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == LAST) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == LAST) ? '0 : rd_q + AW'(1);
			end
		end
	end

	// Occupancy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (push && !pop) begin
			cnt_q <= cnt_q + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_q <= cnt_q - (AW+1)'(1);
		end
	end

	chk_fifo_grow: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
		push && !pop |=> cnt_q == $past(cnt_q) + (AW+1)'(1))
		else $error("fifo count did not grow");
	chk_fifo_bound: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
		cnt_q <= FULL)
		else $error("fifo count beyond depth");
endmodule // ssp_fifo

// ### hw/ssp_clkdiv.sv
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_clkdiv (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic [7:0] presc,
	input wire logic [7:0] scr,
	// Half bit strobe
	output logic tick
);
	import ssp_pkg::*;
	logic [6:0] pre_q;
	logic [7:0] div_q;
	logic [6:0] pre_end;
	logic pre_wrap;

	// Odd prescale rounds down; zero or one still gives one cycle
	assign pre_end = (presc[7:1] == 7'h00) ? 7'h00 : presc[7:1] - 7'h01;
	assign pre_wrap = pre_q == pre_end;

	// Prescaler stage, held clear while idle so each frame starts in phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 7'h00;
		end else if (!run || pre_wrap) begin
			pre_q <= 7'h00;
		end else begin
			pre_q <= pre_q + 7'h01;
		end
	end

	// Bit rate divider counts prescaled steps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 8'h00;
		end else if (!run) begin
			div_q <= 8'h00;
		end else if (pre_wrap) begin
			div_q <= (div_q == scr) ? 8'h00 : div_q + 8'h01;
		end
	end

	// One strobe per half bit: bit period is presc * (scr + 1) cycles for even presc of two or more
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick <= 1'b0;
		end else begin
			tick <= run && pre_wrap && (div_q == scr); // [RQ8]
		end
	end

	chk_tick_gap: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
		tick && run && (presc >= 8'h04) |=> !tick)
		else $error("half bit strobe too fast");
endmodule // ssp_clkdiv

// ### verif/ssp_peri_model.sv
`timescale 1ns/1ps
module ssp_peri_model (
	// Link pins as the peripheral sees them
	input wire logic sclk,
	input wire logic fss_n,
	input wire logic mosi,
	output logic miso,
	// Word to answer with, its length, and the word captured
	input wire logic [15:0] tx_word,
	input wire logic [4:0] nbits,
	output logic [15:0] rx_word
);
	int cnt;
	initial begin
		miso = 1'b0;
		rx_word = 16'h0000;
		cnt = 0;
	end
	// Selected: present the MSB at once, the master samples on its leading edge
	always @(negedge fss_n) begin
		cnt = 0;
		rx_word = 16'h0000;
		miso = tx_word[nbits-1];
	end
	// Capture the master's bits on the leading edge, MSB first
	always @(posedge sclk) begin
		if (!fss_n) begin
			rx_word = {rx_word[14:0], mosi};
		end
	end
	// Next bit on the trailing edge; past the word the line only toggles
	always @(negedge sclk) begin
		if (!fss_n) begin
			cnt++;
			miso = (cnt < nbits) ? tx_word[nbits-1-cnt] : ~miso;
		end
	end
	// Deselected: invert, so nobody can lean on a stale bit
	always @(posedge fss_n) begin
		miso = ~miso;
	end
endmodule // ssp_peri_model

// ### verif/tb_synchronous_serial_port.sv
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module tb_synchronous_serial_port;
	import ssp_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic sclk_o, sclk_oe_n, fss_o, fss_oe_n, txd_o, txd_oe_n;
	logic tb_sclk, tb_fss, tb_rxd, tb_drives, peri_miso;
	logic [15:0] peri_tx, peri_rx;
	logic [4:0] peri_n;
	wire sclk_w, fss_w, txd_w, rxd_w;
	int errors, total_checks;
	// Wire levels from the enables; a released data line shows the inverse, released clock and select take the bench levels
	assign sclk_w = sclk_oe_n ? tb_sclk : sclk_o;
	assign fss_w = fss_oe_n ? tb_fss : fss_o;
	assign txd_w = txd_oe_n ? ~txd_o : txd_o;
	assign rxd_w = tb_drives ? tb_rxd : peri_miso;
	ssp_top #(.FIFO_DEPTH(`SSP_FIFO_DEPTH)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sclk_i(sclk_w), .sclk_o(sclk_o),
		.sclk_oe_n(sclk_oe_n), .fss_i(fss_w), .fss_o(fss_o), .fss_oe_n(fss_oe_n),
		.txd_o(txd_o), .txd_oe_n(txd_oe_n), .rxd_i(rxd_w));
	ssp_peri_model i_peri (.sclk(sclk_w), .fss_n(fss_w), .mosi(txd_w), .miso(peri_miso),
		.tx_word(peri_tx), .nbits(peri_n), .rx_word(peri_rx));
	// Clock
	always #5 pclk = ~pclk;
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// One APB transfer; waits up to 500 cycles for pready
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 500);
		if (pready !== 1'b1) begin
			errors++;
			$display("[ERR] apb ready expected 1 seen timeout");
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		logic e;
		apb(1'b0, a, 32'h00000000, d, e);
	endtask
	// Settings only change while the port is disabled
	task cfg(input ssp_ctrl0_t c0, input logic [7:0] pr, input ssp_ctrl1_t c1);
		wr(`SSP_OFF_CTRL1, 32'h00000000);
		wr(`SSP_OFF_CTRL0, {16'h0000, c0});
		wr(`SSP_OFF_PRESC, {24'h000000, pr});
		wr(`SSP_OFF_CTRL1, {28'h0000000, c1});
	endtask
	task wait_idle;
		logic [31:0] s;
		int n;
		n = 0;
		do begin
			rd(`SSP_OFF_STAT, s);
			n++;
		end while ((s[4] !== 1'b0 || s[0] !== 1'b1) && n < 400);
		if (n >= 400) begin
			errors++;
			$display("[ERR] idle expected 1 seen timeout");
		end
		rd(`SSP_OFF_STAT, s);
	endtask
	task t_reset;
		logic [31:0] d;
		logic e;
		chk("sclk_oe_n", sclk_oe_n, 32'h1);
		chk("txd_oe_n", txd_oe_n, 32'h1);
		rd(`SSP_OFF_CTRL0, d);
		chk("ctrl0", d, {16'h0000, `SSP_RST_CTRL0});
		rd(`SSP_OFF_CTRL1, d);
		chk("ctrl1", d, {28'h0000000, `SSP_RST_CTRL1});
		rd(`SSP_OFF_PRESC, d);
		chk("presc", d, {24'h000000, `SSP_RST_PRESC});
		rd(`SSP_OFF_STAT, d);
		chk("stat", d, 32'h00000003);
		apb(1'b0, 8'h14, 32'h00000000, d, e);
		chk("hole err", e, 32'h1);
		chk("hole data", d, 32'h00000000);
		$display("t_reset done");
	endtask
	// Master SPI mode 0 with the peripheral, then command/response
	task t_master;
		ssp_ctrl0_t c0;
		logic [31:0] d;
		int n;
		c0 = '{scr:8'h01, cpha:1'b0, cpol:1'b0, fmt:SSP_FMT_SPI, dss:4'h7};
		peri_tx <= 16'h003C;
		peri_n <= 5'h08;
		cfg(c0, 8'h08, '{sod:1'b0, slave:1'b0, en:1'b1, loop:1'b0});
		wr(`SSP_OFF_DATA, 32'h000000A5);
		n = 0;
		while (fss_o !== 1'b0 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk("m sclk_oe_n", sclk_oe_n, 32'h0);
		chk("m fss_oe_n", fss_oe_n, 32'h0);
		wait_idle;
		rd(`SSP_OFF_DATA, d);
		chk("m rx", d, 32'h0000003C);
		chk("m peri rx", {16'h0000, peri_rx}, 32'h000000A5);
		c0.fmt = SSP_FMT_CMD;
		peri_tx <= 16'h005A;
		peri_n <= 5'h10;
		cfg(c0, 8'h08, '{sod:1'b0, slave:1'b0, en:1'b1, loop:1'b0});
		wr(`SSP_OFF_DATA, 32'h000000C3);
		wait_idle;
		rd(`SSP_OFF_DATA, d);
		chk("cmd rx", d, 32'h0000005A);
		chk("cmd sent", {24'h000000, peri_rx[15:8]}, 32'h000000C3);
		$display("t_master done");
	endtask
	// Half bit is floor(PRESC/2)*(SCR+1) cycles
	task t_rate;
		ssp_ctrl0_t c0;
		logic [31:0] d;
		int n;
		c0 = '{scr:8'h02, cpha:1'b0, cpol:1'b0, fmt:SSP_FMT_SPI, dss:4'h7};
		cfg(c0, 8'h04, '{sod:1'b0, slave:1'b0, en:1'b1, loop:1'b1});
		wr(`SSP_OFF_DATA, 32'h0000005E);
		n = 0;
		while (sclk_o !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		while (sclk_o === 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk("half bit", n, (4 / 2) * (2 + 1));
		wait_idle;
		rd(`SSP_OFF_DATA, d);
		chk("rate rx", d, 32'h0000005E);
		$display("t_rate done");
	endtask
	// Loopback over the SPI and frame-pulse formats, all four SPI clock modes and boundary lengths
	task t_formats;
		ssp_fmt_t fm[6];
		logic [1:0] pm[6];
		logic [3:0] ds[6];
		logic [15:0] w, m;
		logic [31:0] d;
		fm = '{SSP_FMT_SPI, SSP_FMT_SPI, SSP_FMT_SPI, SSP_FMT_SPI, SSP_FMT_PULSE, SSP_FMT_PULSE};
		pm = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
		ds = '{4'h3, 4'hF, 4'h7, 4'hB, 4'hF, 4'h3};
		for (int i = 0; i < 6; i++) begin
			cfg('{scr:8'h01, cpha:pm[i][0], cpol:pm[i][1], fmt:fm[i], dss:ds[i]}, 8'h04,
				'{sod:1'b0, slave:1'b0, en:1'b1, loop:1'b1});
			repeat (2) @(posedge pclk);
			chk("sclk idle", sclk_o, (fm[i] == SSP_FMT_SPI) ? pm[i][1] : 1'b0);
			chk("fss idle", fss_o, (fm[i] == SSP_FMT_PULSE) ? 1'b0 : 1'b1);
			w = 16'hB6D9 + 16'(i * 37);
			m = 16'hFFFF >> (4'hF - ds[i]);
			wr(`SSP_OFF_DATA, {16'h0000, w});
			wait_idle;
			rd(`SSP_OFF_DATA, d);
			chk("loop rx", d, {16'h0000, w & m});
		end
		$display("t_formats done");
	endtask
	// Fill the transmit side, then let the receive side fill until it blocks
	task t_fifo;
		ssp_ctrl0_t c0;
		logic [31:0] d;
		c0 = '{scr:8'h01, cpha:1'b0, cpol:1'b0, fmt:SSP_FMT_SPI, dss:4'h3};
		cfg(c0, 8'h04, '{sod:1'b0, slave:1'b0, en:1'b0, loop:1'b1});
		for (int i = 1; i <= 8; i++) begin
			wr(`SSP_OFF_DATA, 32'(i));
		end
		rd(`SSP_OFF_STAT, d);
		chk("tx full stat", d, 32'h00000010);
		wr(`SSP_OFF_CTRL1, 32'h00000003);
		wait_idle;
		rd(`SSP_OFF_STAT, d);
		chk("rx full stat", d, 32'h0000000F);
		wr(`SSP_OFF_DATA, 32'h00000009);
		repeat (40) @(posedge pclk);
		rd(`SSP_OFF_STAT, d);
		chk("held stat", d, 32'h0000001E);
		for (int i = 1; i <= 9; i++) begin
			if (i == 9) begin
				wait_idle;
			end
			rd(`SSP_OFF_DATA, d);
			chk("fifo rx", d, 32'(i));
		end
		rd(`SSP_OFF_DATA, d);
		chk("empty rx", d, 32'h00000000);
		$display("t_fifo done");
	endtask
	// Slave: undriven output when asked, then a full frame from the bench
	task t_slave;
		ssp_ctrl0_t c0;
		logic [31:0] d;
		logic [7:0] got, b;
		c0 = '{scr:8'h01, cpha:1'b0, cpol:1'b0, fmt:SSP_FMT_SPI, dss:4'h7};
		b = 8'h96;
		tb_drives <= 1'b1;
		cfg(c0, 8'h08, '{sod:1'b1, slave:1'b1, en:1'b1, loop:1'b0});
		tb_fss <= 1'b0;
		repeat (8) @(posedge pclk);
		chk("sod txd_oe_n", txd_oe_n, 32'h1);
		chk("s sclk_oe_n", sclk_oe_n, 32'h1);
		chk("s fss_oe_n", fss_oe_n, 32'h1);
		tb_fss <= 1'b1;
		cfg(c0, 8'h08, '{sod:1'b0, slave:1'b1, en:1'b1, loop:1'b0});
		wr(`SSP_OFF_DATA, 32'h000000C3);
		tb_fss <= 1'b0;
		repeat (8) @(posedge pclk);
		chk("s txd_oe_n", txd_oe_n, 32'h0);
		for (int k = 7; k >= 0; k--) begin
			tb_rxd <= b[k];
			repeat (8) @(posedge pclk);
			got[k] = txd_o;
			tb_sclk <= 1'b1;
			repeat (8) @(posedge pclk);
			tb_sclk <= 1'b0;
		end
		repeat (8) @(posedge pclk);
		tb_fss <= 1'b1;
		tb_rxd <= ~tb_rxd;
		repeat (4) @(posedge pclk);
		rd(`SSP_OFF_DATA, d);
		chk("s rx", d, 32'h00000096);
		chk("s tx", {24'h000000, got}, 32'h000000C3);
		$display("t_slave done");
	endtask
	// Main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		tb_sclk = 1'b0;
		tb_fss = 1'b1;
		tb_rxd = 1'b0;
		tb_drives = 1'b0;
		peri_tx = 16'h0000;
		peri_n = 5'h08;
		errors = 0;
		total_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_master;
		t_rate;
		t_formats;
		t_fifo;
		t_slave;
		tally_and_finish;
	end
	// Watchdog: the tests need well under a third of this span
	initial begin
		repeat (60000) @(posedge pclk);
		errors++;
		$display("[ERR] watchdog expected finish seen timeout");
		tally_and_finish;
	end
endmodule // tb_synchronous_serial_port
